// [spi_err_core.v]
// Serial port core: clock modes, error flags, interrupt and wake-up logic
// Notes on behaviour
// - Polarity and phase pick the capture edge
// - Master with select low is a fault
// - Fault sets flag, interrupt if enabled
// - Fault clears port enable and master
// - Fault cleared by status read, control write
// - Enable and master refused while fault set
// - Overrun when byte ends with done set
// - Overrun sets flag, interrupt if enabled
// - Buffer keeps first byte, later bytes dropped
// - Status read clears overrun flag
// - Data write mid-transfer ignored, collision flagged unless done is pending unacknowledged
// - Collision flag never raises an interrupt
// - Receive buffer read synchronously, never collides
// - Wait mode unaffected, events wake from wait
// - Halt freezes registers, overrun if several bytes
// - Slave transfer-done wakes from halt
// - Halt wake needs select low at entry
// - Only transfer-done exits halt, shared enable
// - One interrupt, needs enable and unmasked CPU
// - Done cleared by status access, data access
`include "spi_err_regs.vh"

module spi_err_core (
  input  wire       i_ref_clk,
  input  wire       i_rst_n,
  input  wire       i_cr_wr,
  input  wire       i_cr_int_en,
  input  wire       i_cr_port_en,
  input  wire       i_cr_master,
  input  wire       i_cr_clock_polarity_bit,
  input  wire       i_cr_clock_phase_bit,
  input  wire [2:0] i_cr_baud,
  input  wire       i_csr_rd,
  input  wire       i_csr_wr,
  input  wire       i_csr_ssm,
  input  wire       i_csr_ssi,
  input  wire       i_dr_rd,
  input  wire       i_dr_wr,
  input  wire [7:0] i_dr_wdata,
  input  wire       i_int_mask,
  input  wire       i_wait,
  input  wire       i_halt,
  input  wire       i_sck,
  input  wire       i_mosi,
  input  wire       i_miso,
  input  wire       i_ss_n,
  output wire       o_sck,
  output wire       o_sck_oe,
  output wire       o_mosi,
  output wire       o_mosi_oe,
  output wire       o_miso,
  output wire       o_miso_oe,
  output wire       o_int_en,
  output wire       o_port_en,
  output wire       o_master,
  output wire       o_clock_polarity_bit,
  output wire       o_clock_phase_bit,
  output wire [2:0] o_baud,
  output wire       o_ssm,
  output wire       o_ssi,
  output wire       o_transfer_done,
  output wire       o_write_collision,
  output wire       o_overrun,
  output wire       o_mode_fault,
  output wire [7:0] o_rx_data,
  output wire       o_busy,
  output wire       o_irq,
  output wire       o_wait_wake,
  output wire       o_halt_wake
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  wire [3:0] pin_s;
  wire       sck_s  = pin_s[0];
  wire       mosi_s = pin_s[1];
  wire       miso_s = pin_s[2];
  wire       ss_n_s = pin_s[3];

  spi_pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_ss_n, i_miso, i_mosi, i_sck}),
    .o_sync    (pin_s)
  );

  reg       int_en_reg;
  reg       port_en_reg;
  reg       master_reg;
  reg       clock_polarity_bit_reg;
  reg       clock_phase_bit_reg;
  reg [2:0] baud_reg;
  reg       ssm_reg;
  reg       ssi_reg;
  reg       tdone_reg;
  reg       tdone_arm_reg;
  reg       write_collision_flag_reg;
  reg       write_collision_flag_arm_reg;
  reg       ovr_reg;
  reg       mode_fault_flag_reg;
  reg       mode_fault_flag_arm_reg;
  reg [7:0] rx_reg;
  reg [7:0] sh_reg;
  reg       tx_bit_reg;
  reg [1:0] mst_state_reg;
  reg [6:0] div_reg;
  reg [3:0] edge_cnt_reg;
  reg       sck_reg;
  reg       sck_d_reg;
  reg [2:0] slv_cnt_reg;
  reg       halt_d_reg;
  reg       halt_ss_low_reg;

  // Software strobes only count while the CPU runs
  wire sw_on    = ~i_halt;
  wire csr_rd   = i_csr_rd & sw_on;
  wire csr_acc  = (i_csr_rd | i_csr_wr) & sw_on;
  wire cr_wr    = i_cr_wr & sw_on;
  wire csr_wr   = i_csr_wr & sw_on;
  wire dr_acc   = (i_dr_rd | i_dr_wr) & sw_on;

  wire ss_eff   = ssm_reg ? ssi_reg : ss_n_s;
  wire mst_run  = mst_state_reg == ST_RUN;

  wire mode_fault_flag_set = master_reg & ~ss_eff;
  wire mode_fault_flag_clr = mode_fault_flag_arm_reg & cr_wr;
  wire ctl_ok   = ~mode_fault_flag_reg | mode_fault_flag_clr;

  // Slave listens in halt only when selected at halt entry
  wire slv_act  = port_en_reg & ~master_reg & ~ss_eff & (sw_on | halt_ss_low_reg);

  reg [6:0] half_cnt;
  always @*
  begin
    case (baud_reg)
      `SPI_BAUD_DIV4:   half_cnt = `SPI_HALF_DIV4;
      `SPI_BAUD_DIV8:   half_cnt = `SPI_HALF_DIV8;
      `SPI_BAUD_DIV16:  half_cnt = `SPI_HALF_DIV16;
      `SPI_BAUD_DIV32:  half_cnt = `SPI_HALF_DIV32;
      `SPI_BAUD_DIV64:  half_cnt = `SPI_HALF_DIV64;
      `SPI_BAUD_DIV128: half_cnt = `SPI_HALF_DIV128;
      default:          half_cnt = `SPI_HALF_DIV128;
    endcase
  end

  wire m_edge   = mst_run & (div_reg == half_cnt - 7'h01);
  wire m_lead   = ~edge_cnt_reg[0];
  wire s_edge   = slv_act & (sck_s != sck_d_reg);
  wire s_lead   = sck_d_reg == clock_polarity_bit_reg;
  wire edge_ev  = mst_run ? m_edge : s_edge;
  wire lead     = mst_run ? m_lead : s_lead;
  wire cap_ev   = edge_ev & (lead ^ clock_phase_bit_reg);
  wire lau_ev   = edge_ev & ~(lead ^ clock_phase_bit_reg);
  wire cap_bit  = mst_run ? miso_s : mosi_s;

  wire m_done   = m_edge & (edge_cnt_reg == `SPI_EDGES_PER_BYTE);
  wire s_done   = s_edge & cap_ev & (slv_cnt_reg == `SPI_LAST_BIT);
  wire complete = m_done | s_done;
  wire [7:0] done_byte = cap_ev ? {sh_reg[6:0], cap_bit} : sh_reg;

  wire busy     = mst_run | (slv_cnt_reg != 3'h0);
  wire tdone_clr = tdone_arm_reg & dr_acc;
  wire tdone_hold = tdone_reg & ~tdone_clr;
  wire ovr_set  = complete & tdone_hold;

  // Data writes are held off while done is pending and unacknowledged
  wire dr_wr_ok = i_dr_wr & sw_on & ~(tdone_reg & ~tdone_arm_reg);
  wire dr_load  = dr_wr_ok & ~busy;
  wire write_collision_flag_set = dr_wr_ok & busy;
  wire write_collision_flag_clr = write_collision_flag_arm_reg & dr_acc;

  // Control bits; a fault overrides the same-cycle write of enable and master
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      int_en_reg  <= `SPI_RST_CTRL;
      port_en_reg <= `SPI_RST_CTRL;
      master_reg  <= `SPI_RST_CTRL;
      clock_polarity_bit_reg    <= `SPI_RST_CTRL;
      clock_phase_bit_reg    <= `SPI_RST_CTRL;
      baud_reg    <= `SPI_RST_BAUD;
      ssm_reg     <= `SPI_RST_CTRL;
      ssi_reg     <= `SPI_RST_CTRL;
    end
    else
    begin
      if (cr_wr)
      begin
        int_en_reg <= i_cr_int_en;
        clock_polarity_bit_reg   <= i_cr_clock_polarity_bit;
        clock_phase_bit_reg   <= i_cr_clock_phase_bit;
        baud_reg   <= i_cr_baud;
      end
      if (mode_fault_flag_set)
      begin
        port_en_reg <= 1'b0;
        master_reg  <= 1'b0;
      end
      else if (cr_wr)
      begin
        port_en_reg <= i_cr_port_en & ctl_ok;
        master_reg  <= i_cr_master & ctl_ok;
      end
      if (csr_wr)
      begin
        ssm_reg <= i_csr_ssm;
        ssi_reg <= i_csr_ssi;
      end
    end
  end

  // Status flags: a hardware set always beats a same-cycle clear
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tdone_reg     <= `SPI_RST_CTRL;
      tdone_arm_reg <= `SPI_RST_CTRL;
      write_collision_flag_reg      <= `SPI_RST_CTRL;
      write_collision_flag_arm_reg  <= `SPI_RST_CTRL;
      ovr_reg       <= `SPI_RST_CTRL;
      mode_fault_flag_reg      <= `SPI_RST_CTRL;
      mode_fault_flag_arm_reg  <= `SPI_RST_CTRL;
      rx_reg        <= `SPI_RST_DATA;
    end
    else
    begin
      tdone_reg     <= complete | tdone_hold;
      tdone_arm_reg <= ~complete & tdone_hold & (tdone_arm_reg | csr_acc);
      write_collision_flag_reg      <= write_collision_flag_set | (write_collision_flag_reg & ~write_collision_flag_clr);
      write_collision_flag_arm_reg  <= ~write_collision_flag_set & write_collision_flag_reg & ~write_collision_flag_clr & (write_collision_flag_arm_reg | csr_rd);
      ovr_reg       <= ovr_set | (ovr_reg & ~csr_rd);
      mode_fault_flag_reg      <= mode_fault_flag_set | (mode_fault_flag_reg & ~mode_fault_flag_clr);
      mode_fault_flag_arm_reg  <= ~mode_fault_flag_set & mode_fault_flag_reg & ~mode_fault_flag_clr & (mode_fault_flag_arm_reg | csr_rd);
      // Only a byte landing with done clear reaches the buffer
      if (complete & ~tdone_hold)
      begin
        rx_reg <= done_byte;
      end
    end
  end

  // Shift engine shared by master and slave
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sh_reg      <= `SPI_RST_DATA;
      tx_bit_reg  <= `SPI_RST_CTRL;
      slv_cnt_reg <= 3'h0;
      sck_d_reg   <= `SPI_SYNC_RST;
    end
    else
    begin
      sck_d_reg <= sck_s;
      if (dr_load)
      begin
        sh_reg     <= i_dr_wdata;
        tx_bit_reg <= i_dr_wdata[7];
      end
      else
      begin
        if (cap_ev)
        begin
          sh_reg <= {sh_reg[6:0], cap_bit};
        end
        if (lau_ev)
        begin
          tx_bit_reg <= sh_reg[7];
        end
        else if (s_done)
        begin
          tx_bit_reg <= sh_reg[6];
        end
      end
      if (!slv_act)
      begin
        slv_cnt_reg <= 3'h0;
      end
      else if (s_edge & cap_ev)
      begin
        slv_cnt_reg <= slv_cnt_reg + 3'h1;
      end
    end
  end

  // Master clock generator; stalls in halt and stops on a fault
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mst_state_reg <= ST_IDLE;
      div_reg       <= 7'h00;
      edge_cnt_reg  <= 4'h0;
      sck_reg       <= `SPI_RST_CTRL;
    end
    else
    begin
      case (mst_state_reg)
        ST_IDLE:
        begin
          sck_reg      <= clock_polarity_bit_reg;
          div_reg      <= 7'h00;
          edge_cnt_reg <= 4'h0;
          if (dr_load & master_reg & port_en_reg & ~mode_fault_flag_set)
          begin
            mst_state_reg <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (mode_fault_flag_set | ~port_en_reg)
          begin
            mst_state_reg <= ST_IDLE;
          end
          else if (sw_on)
          begin
            if (m_edge)
            begin
              div_reg      <= 7'h00;
              sck_reg      <= ~sck_reg;
              edge_cnt_reg <= edge_cnt_reg + 4'h1;
              if (m_done)
              begin
                mst_state_reg <= ST_IDLE;
              end
            end
            else
            begin
              div_reg <= div_reg + 7'h01;
            end
          end
        end
        default:
        begin
          mst_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Select level seen as halt begins decides halt wake-up
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      halt_d_reg      <= `SPI_RST_CTRL;
      halt_ss_low_reg <= `SPI_RST_CTRL;
    end
    else
    begin
      halt_d_reg <= i_halt;
      if (i_halt & ~halt_d_reg)
      begin
        halt_ss_low_reg <= ~ss_eff;
      end
    end
  end

  // Collision flag deliberately left out of every request
  wire any_ev = tdone_reg
                | ovr_reg
                | mode_fault_flag_reg;

  assign o_irq       = int_en_reg & ~i_int_mask & any_ev;
  assign o_wait_wake = i_wait & int_en_reg & any_ev;
  assign o_halt_wake = i_halt & int_en_reg & tdone_reg & ~master_reg
                       & halt_ss_low_reg;

  assign o_sck       = sck_reg;
  assign o_sck_oe    = port_en_reg & master_reg;
  assign o_mosi      = tx_bit_reg;
  assign o_mosi_oe   = port_en_reg & master_reg;
  assign o_miso      = tx_bit_reg;
  assign o_miso_oe   = port_en_reg & ~master_reg & ~ss_eff;

  assign o_int_en          = int_en_reg;
  assign o_port_en         = port_en_reg;
  assign o_master          = master_reg;
  assign o_clock_polarity_bit            = clock_polarity_bit_reg;
  assign o_clock_phase_bit            = clock_phase_bit_reg;
  assign o_baud            = baud_reg;
  assign o_ssm             = ssm_reg;
  assign o_ssi             = ssi_reg;
  assign o_transfer_done   = tdone_reg;
  assign o_write_collision = write_collision_flag_reg;
  assign o_overrun         = ovr_reg;
  assign o_mode_fault      = mode_fault_flag_reg;
  assign o_rx_data         = rx_reg;
  assign o_busy            = busy;

endmodule // spi_err_core

// [spi_err_regs.vh]
// Constants for the serial port error, flag and low-power logic
`ifndef SPI_ERR_REGS_VH
`define SPI_ERR_REGS_VH

`define SPI_BYTE_BITS       8
`define SPI_EDGES_PER_BYTE  4'hF
`define SPI_LAST_BIT        3'h7
`define SPI_HALF_W          7

`define SPI_BAUD_DIV4       3'h4
`define SPI_BAUD_DIV8       3'h0
`define SPI_BAUD_DIV16      3'h1
`define SPI_BAUD_DIV32      3'h6
`define SPI_BAUD_DIV64      3'h2
`define SPI_BAUD_DIV128     3'h3

`define SPI_HALF_DIV4       7'h02
`define SPI_HALF_DIV8       7'h04
`define SPI_HALF_DIV16      7'h08
`define SPI_HALF_DIV32      7'h10
`define SPI_HALF_DIV64      7'h20
`define SPI_HALF_DIV128     7'h40

`define SPI_RST_CTRL        1'h0
`define SPI_RST_BAUD        3'h0
`define SPI_RST_DATA        8'h00
`define SPI_SYNC_RST        1'h1

`endif

// [spi_pin_sync.v]
// Two-flop synchroniser for the serial pins
module spi_pin_sync #(
  parameter WIDTH = 4
) (
  input  wire             i_ref_clk,
  input  wire             i_rst_n,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      // Idle-high reset keeps select and clock lines inactive
      always @(posedge i_ref_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta_reg[g] <= 1'b1;
          sync_reg[g] <= 1'b1;
        end
        else
        begin
          meta_reg[g] <= i_async[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_reg;

endmodule // spi_pin_sync

// [spi_err_checker.sv]
// Concurrent checks on the serial port error and wake-up core
module spi_err_checker (
  input wire       i_ref_clk,
  input wire       i_rst_n,
  input wire       i_cr_wr,
  input wire       i_csr_rd,
  input wire       i_dr_wr,
  input wire       i_int_mask,
  input wire       i_halt,
  input wire       o_sck_oe,
  input wire       o_mosi_oe,
  input wire       o_miso_oe,
  input wire       o_int_en,
  input wire       o_port_en,
  input wire       o_master,
  input wire       o_transfer_done,
  input wire       o_write_collision,
  input wire       o_overrun,
  input wire       o_mode_fault,
  input wire [7:0] o_rx_data,
  input wire       o_busy,
  input wire       o_irq,
  input wire       o_halt_wake
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen_reg;
  // Status read seen while faulted, armed until the next control write
  always @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      seen_reg <= 1'b0;
    else if (i_cr_wr && !i_halt)
      seen_reg <= 1'b0;
    else if (i_csr_rd && o_mode_fault && !i_halt)
      seen_reg <= 1'b1;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence fault_rd;
    o_mode_fault && i_csr_rd && !i_halt;
  endsequence
  sequence cr_write;
    i_cr_wr && !i_halt;
  endsequence
  irq_rule_a:
    assert property (o_irq == (o_int_en && !i_int_mask
      && (o_transfer_done || o_overrun || o_mode_fault))) else $error("irq wrong");
  write_collision_flag_quiet_a:
    assert property (o_write_collision && !o_transfer_done && !o_overrun && !o_mode_fault
      |-> !o_irq) else $error("collision irq");
  fault_cause_a:
    assert property ($rose(o_mode_fault) |-> $past(o_master)) else $error("fault cause");
  fault_cut_a:
    assert property ($rose(o_mode_fault) |-> !o_port_en && !o_master) else $error("fault cut");
  fault_lock_a:
    assert property (o_mode_fault && i_cr_wr && !i_halt && !seen_reg && !i_csr_rd
      |=> !o_port_en && !o_master) else $error("enable taken");
  fault_clr_a:
    assert property (fault_rd ##[1:4] cr_write |=> !o_mode_fault) else $error("fault stuck");
  ovr_clr_a:
    assert property (o_overrun && i_csr_rd && !i_halt |=> !o_overrun) else $error("ovr stuck");
  rx_hold_a:
    assert property (o_transfer_done && $past(o_transfer_done) |-> $stable(o_rx_data))
      else $error("rx changed");
  write_collision_flag_set_a:
    assert property (o_busy && i_dr_wr && !i_halt && !o_transfer_done |=> o_write_collision)
      else $error("no write_collision_flag");
  pins_off_a:
    assert property (!o_port_en |-> !o_sck_oe && !o_mosi_oe && !o_miso_oe)
      else $error("pin driven");
  halt_wake_a:
    assert property (o_halt_wake |-> i_halt && o_transfer_done && o_int_en && !o_master)
      else $error("bad halt wake");
endmodule // spi_err_checker

bind spi_err_core spi_err_checker chk (.*);

// [far_master.sv]
// Far-side serial master model for the slave link
module far_master (
  input  wire  i_miso,
  output logic o_sck,
  output logic o_mosi,
  output logic o_ss_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got;
  initial
  begin
    o_sck = 1'b0;
    o_mosi = 1'b1;
    o_ss_n = 1'b1;
  end
  // Idle-low clock, first edge captures; clock still outside frames
  task automatic xfer(input logic [7:0] b);
    o_ss_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      o_mosi = b[i];
      #80 o_sck = 1'b1;
      got[i] = i_miso;
      #80 o_sck = 1'b0;
    end
    #80 o_ss_n = 1'b1;
    o_mosi = ~o_mosi;
  endtask
endmodule // far_master

// [testbench.sv]
// Self-checking bench for the serial port error and wake-up core
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk, i_rst_n, i_cr_wr, i_cr_int_en, i_cr_port_en, i_cr_master, i_cr_clock_polarity_bit;
  logic i_cr_clock_phase_bit, i_csr_rd, i_csr_wr, i_csr_ssm, i_csr_ssi, i_dr_rd, i_dr_wr, i_int_mask;
  logic i_wait, i_halt, i_sck, i_mosi, i_miso, i_ss_n, tb_ss_n, far_ss_n;
  logic o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_int_en, o_port_en;
  logic o_master, o_clock_polarity_bit, o_clock_phase_bit, o_ssm, o_ssi, o_transfer_done, o_write_collision;
  logic o_overrun, o_mode_fault, o_busy, o_irq, o_wait_wake, o_halt_wake;
  logic [2:0] i_cr_baud, o_baud;
  logic [7:0] i_dr_wdata, o_rx_data;
  int errors, checks, cyc;
  // Master mode loops its own data line back
  assign i_miso = o_mosi;
  assign i_ss_n = tb_ss_n & far_ss_n;
  spi_err_core dut (.*);
  far_master far (.i_miso(o_miso), .o_sck(i_sck), .o_mosi(i_mosi), .o_ss_n(far_ss_n));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cr(input logic ie, input logic en, input logic ms, input logic cp);
    @(posedge i_ref_clk);
    {i_cr_wr, i_cr_int_en, i_cr_port_en, i_cr_master} <= {1'b1, ie, en, ms};
    {i_cr_clock_polarity_bit, i_cr_clock_phase_bit} <= {cp, cp};
    @(posedge i_ref_clk);
    i_cr_wr <= 1'b0;
    #1;
  endtask
  // k is {data write, data read, status read}
  task automatic sw(input logic [2:0] k);
    @(posedge i_ref_clk);
    {i_dr_wr, i_dr_rd, i_csr_rd} <= k;
    @(posedge i_ref_clk);
    {i_dr_wr, i_dr_rd, i_csr_rd} <= 3'h0;
    #1;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 300 && o_transfer_done !== 1'b1; i++)
      @(posedge i_ref_clk);
    #1;
  endtask
  task automatic t_master();
    i_int_mask <= 1'b0;
    cr(1'b1, 1'b1, 1'b1, 1'b1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk("sck idle", o_sck, 1'b1);
    i_dr_wdata <= 8'h3C;
    sw(3'h4);
    i_dr_wdata <= 8'h55;
    sw(3'h4);
    chk("write_collision_flag", o_write_collision, 1'b1);
    chk("write_collision_flag irq", o_irq, 1'b0);
    wait_done();
    chk("master rx", o_rx_data, 8'h3C);
    chk("done irq", o_irq, 1'b1);
    i_int_mask <= 1'b1;
    i_wait <= 1'b1;
    #20 chk("masked", o_irq, 1'b0);
    chk("wait wake", o_wait_wake, 1'b1);
    i_wait <= 1'b0;
    sw(3'h1);
    sw(3'h2);
    chk("done clr", o_transfer_done, 1'b0);
    chk("write_collision_flag clr", o_write_collision, 1'b0);
  endtask
  task automatic t_fault();
    i_int_mask <= 1'b0;
    tb_ss_n <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    #1 chk("fault", o_mode_fault, 1'b1);
    chk("fault irq", o_irq, 1'b1);
    chk("fault off", {o_port_en, o_master}, 2'h0);
    tb_ss_n <= 1'b1;
    cr(1'b1, 1'b1, 1'b1, 1'b1);
    chk("refused", {o_port_en, o_master}, 2'h0);
    sw(3'h1);
    cr(1'b1, 1'b1, 1'b1, 1'b1);
    chk("fault clr", o_mode_fault, 1'b0);
    chk("restored", {o_port_en, o_master}, 2'h3);
    cr(1'b0, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_slave();
    cr(1'b1, 1'b1, 1'b0, 1'b0);
    far.xfer(8'hA5);
    wait_done();
    chk("slave rx", o_rx_data, 8'hA5);
    far.xfer(8'h5A);
    repeat (6) @(posedge i_ref_clk);
    #1 chk("overrun", o_overrun, 1'b1);
    chk("ovr irq", o_irq, 1'b1);
    chk("ovr keep", o_rx_data, 8'hA5);
    sw(3'h1);
    chk("ovr clr", o_overrun, 1'b0);
    sw(3'h2);
  endtask
  task automatic t_halt();
    @(posedge i_ref_clk);
    {i_csr_wr, i_csr_ssm, i_csr_ssi} <= 3'h6;
    @(posedge i_ref_clk);
    i_csr_wr <= 1'b0;
    i_halt <= 1'b1;
    far.xfer(8'hC3);
    wait_done();
    chk("halt wake", o_halt_wake, 1'b1);
    i_halt <= 1'b0;
    #20 chk("halt rx", o_rx_data, 8'hC3);
    chk("wake off", o_halt_wake, 1'b0);
    sw(3'h1);
    sw(3'h2);
    far.xfer(8'h96);
    wait_done();
    chk("extra rx", o_rx_data, 8'h96);
  endtask
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    {i_rst_n, i_cr_wr, i_cr_int_en, i_cr_port_en, i_cr_master, i_cr_clock_polarity_bit} = 6'h00;
    {i_cr_clock_phase_bit, i_csr_rd, i_csr_wr, i_csr_ssm, i_csr_ssi, i_dr_rd, i_dr_wr} = 7'h00;
    {i_wait, i_halt, i_int_mask, tb_ss_n} = 4'h3;
    i_cr_baud = 3'h1;
    i_dr_wdata = 8'h00;
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    #1 chk("reset", {o_port_en, o_irq, o_sck_oe, o_mode_fault}, 4'h0);
    t_master();
    t_fault();
    t_slave();
    t_halt();
    finish_test();
  end
endmodule // testbench
